// file: hdl/imts_chan_node.sv
`timescale 1ns/100ps
`default_nettype none
`include "imts_defs.svh"

module imts_chan_node (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	imts_bus_if.oth bus,
	input wire logic xfer_req_i,
	input wire logic xfer_in_i,
	input wire imts_pkg::imts_byte_t xfer_wdata_i,
	output imts_pkg::imts_byte_t xfer_rdata_o,
	output logic xfer_done_o,
	output logic xfer_busy_o,
	output imts_pkg::imts_period_t period_o
);
	import imts_pkg::*;

	typedef struct packed {
		logic [1:0] mclk_s;
		logic [1:0] bstr_s;
		logic [1:0] ack_s;
		logic [1:0][7:0] data_s;
		logic mclk_prev;
		logic bstr_prev;
		logic align;
		logic pend;
		logic in;
		imts_byte_t wdata;
		logic req_n;
		logic granted;
		logic oe;
		imts_byte_t rdata;
		logic done;
	} imts_cn_st_t;

	imts_cn_st_t q;
	imts_cn_st_t d;
	imts_period_t period;
	imts_period_t np;
	logic rise;
	logic fall;
	logic bstr_fall;

	// ==========================================
	// Local timing from synchronised master clock and late strobe
	assign rise = q.mclk_s[1] & ~q.mclk_prev;
	assign fall = ~q.mclk_s[1] & q.mclk_prev;
	assign bstr_fall = ~q.bstr_s[1] & q.bstr_prev;
	assign np = rise ? (q.align ? `IMTS_ALIGN_PERIOD : 3'(period + 3'h1)) : period;

	imts_period_ctr u_period (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.adv_i(rise),
		.load_i(q.align),
		.load_val_i(`IMTS_ALIGN_PERIOD),
		.period_o(period)
	);

	always_comb begin
		d = q;
		d.done = 1'b0;
		d.mclk_s = {q.mclk_s[0], bus.master_time_base};
		d.bstr_s = {q.bstr_s[0], bus.buffered_strobe_n};
		d.ack_s = {q.ack_s[0], bus.chan_ack};
		d.data_s = {q.data_s[0], bus.shared_data_lines};
		d.mclk_prev = q.mclk_s[1];
		d.bstr_prev = q.bstr_s[1];
		// Strobe edge never times anything; it only arms the next realign
		d.align = (q.align & ~rise) | bstr_fall;

		if (xfer_req_i && !q.pend) begin
			d.pend = 1'b1;
			d.in = xfer_in_i;
			d.wdata = xfer_wdata_i;
		end
		if (q.pend && !q.granted && fall) begin
			d.req_n = 1'b0;
		end
		if (q.pend && q.ack_s[1]) begin
			d.granted = 1'b1;
			d.req_n = 1'b1;
		end
		// Local periods trail by a period and a half; drive ends early in local T6
		d.oe = d.granted & q.in & ((np == `IMTS_T4) | (np == `IMTS_T5) |
			(rise & (np == `IMTS_T6)));
		if (q.granted && fall && period == `IMTS_T7) begin
			if (!q.in) begin
				d.rdata = q.data_s[1];
			end
			d.done = 1'b1;
			d.pend = 1'b0;
			d.granted = 1'b0;
			d.oe = 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			q <= '0;
			q.bstr_s <= 2'h3;
			q.bstr_prev <= 1'b1;
			q.req_n <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign bus.oth_data_out = q.wdata;
	assign bus.oth_data_oe = q.oe;
	assign bus.chan_req_n = q.req_n;
	assign bus.chan_in_n = ~q.in;
	assign xfer_rdata_o = q.rdata;
	assign xfer_done_o = q.done;
	assign xfer_busy_o = q.pend;
	assign period_o = period;
endmodule : imts_chan_node

`default_nettype wire

// file: hdl/imts_period_ctr.sv
`timescale 1ns/100ps
`default_nettype none
`include "imts_defs.svh"

module imts_period_ctr (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic adv_i,
	input wire logic load_i,
	input wire imts_pkg::imts_period_t load_val_i,
	output imts_pkg::imts_period_t period_o
);
	import imts_pkg::*;

	typedef struct packed {
		imts_period_t period;
	} imts_pc_st_t;

	imts_pc_st_t q;
	imts_pc_st_t d;

	// ==========================================
	// Eight periods per machine cycle, wraps T7 to T0
	always_comb begin
		d = q;
		if (adv_i) begin
			d.period = load_i ? load_val_i : 3'(q.period + 3'h1);
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			q.period <= `IMTS_T0;
		end else begin
			q <= d;
		end
	end

	assign period_o = q.period;
endmodule : imts_period_ctr

`default_nettype wire

// file: hdl/imts_slot_master.sv
`timescale 1ns/100ps
`default_nettype none
`include "imts_defs.svh"

module imts_slot_master #(
	parameter int HALF_CYC = `IMTS_MCLK_HALF_CYC,
	parameter int STRB_DLY = `IMTS_STRB_DLY_CYC,
	parameter int MEM_AW = `IMTS_MEM_AW
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	imts_bus_if.dev bus,
	input wire logic video_req_i,
	input wire logic video_wr_i,
	input wire imts_pkg::imts_addr_t video_addr_i,
	input wire imts_pkg::imts_byte_t video_wdata_i,
	input wire logic main_req_i,
	input wire logic main_wr_i,
	input wire imts_pkg::imts_addr_t main_addr_i,
	input wire imts_pkg::imts_byte_t main_wdata_i,
	input wire logic [2:0] main_io_sel_i,
	input wire logic chan_enable_i,
	output imts_pkg::imts_period_t period_o,
	output imts_pkg::imts_byte_t video_rdata_o,
	output logic video_done_o,
	output imts_pkg::imts_byte_t main_rdata_o,
	output logic main_done_o,
	output logic chan_done_o
);
	import imts_pkg::*;

	localparam int HW = $clog2(HALF_CYC + 1);
	localparam int DEPTH = 1 << MEM_AW;

	typedef struct packed {
		logic [HW-1:0] div;
		logic mclk;
		logic strobe;
		logic [STRB_DLY-1:0] strobe_sh;
		logic bstrobe_n;
		logic [1:0] req_sync;
		logic [1:0] in_sync;
		logic read_n;
		logic write_n;
		imts_byte_t addr;
		imts_byte_t dout;
		logic doe;
		logic chan_ack;
		logic [2:0] io_sel;
		logic v_act;
		logic v_wr;
		imts_addr_t v_addr;
		imts_byte_t v_wdata;
		logic m_act;
		logic m_wr;
		logic m_chan;
		imts_addr_t m_addr;
		imts_byte_t m_wdata;
		imts_addr_t dma_ptr;
		imts_byte_t v_rdata;
		imts_byte_t m_rdata;
		logic v_done;
		logic m_done;
		logic c_done;
		logic [DEPTH-1:0][7:0] mem;
	} imts_sm_st_t;

	imts_sm_st_t q;
	imts_sm_st_t d;
	imts_period_t period;
	imts_period_t np;
	imts_owner_t own;
	imts_owner_t own_old;
	logic tick;
	logic adv;
	logic act;
	logic wr;
	logic old_act;
	logic old_wr;
	logic [MEM_AW-1:0] idx;
	logic [MEM_AW-1:0] old_idx;

	// ==========================================
	// Master time base and period counter
	assign tick = (q.div == HW'(HALF_CYC - 1));
	assign adv = tick & ~q.mclk;
	assign np = adv ? 3'(period + 3'h1) : period;

	imts_period_ctr u_period (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.adv_i(adv),
		.load_i(1'b0),
		.load_val_i(`IMTS_T0),
		.period_o(period)
	);

	// ==========================================
	// Slot ownership, upper half of the cycle is the main processor
	always_comb begin
		own = np[2] ? IMTS_OWN_MAIN : IMTS_OWN_VIDEO;
		own_old = period[2] ? IMTS_OWN_MAIN : IMTS_OWN_VIDEO;
	end

	always_comb begin
		d = q;
		d.v_done = 1'b0;
		d.m_done = 1'b0;
		d.c_done = 1'b0;
		d.div = tick ? '0 : HW'(q.div + 1'b1);
		if (tick) begin
			d.mclk = ~q.mclk;
		end
		d.strobe = (np == `IMTS_T7);
		// Fed from the next strobe so the late copy trails by exactly STRB_DLY
		d.strobe_sh = STRB_DLY'({q.strobe_sh, d.strobe});
		// Late copy of the strobe, far boards only align to it
		d.bstrobe_n = ~q.strobe_sh[STRB_DLY-1];
		d.req_sync = {q.req_sync[0], ~bus.chan_req_n};
		d.in_sync = {q.in_sync[0], ~bus.chan_in_n};

		// Completion at slot end: write or read as T3 or T7 ends
		old_act = (own_old == IMTS_OWN_MAIN) ? q.m_act : q.v_act;
		old_wr = (own_old == IMTS_OWN_MAIN) ? q.m_wr : q.v_wr;
		old_idx = (own_old == IMTS_OWN_MAIN) ? q.m_addr[MEM_AW-1:0] : q.v_addr[MEM_AW-1:0];
		if (adv && (period == `IMTS_T3 || period == `IMTS_T7) && old_act) begin
			if (old_wr) begin
				d.mem[old_idx] = bus.shared_data_lines;
			end
			if (own_old == IMTS_OWN_VIDEO) begin
				d.v_done = 1'b1;
				if (!old_wr) begin
					d.v_rdata = bus.shared_data_lines;
				end
			end else if (q.m_chan) begin
				d.c_done = 1'b1;
				d.dma_ptr = 16'(q.dma_ptr + 16'h0001);
			end else begin
				d.m_done = 1'b1;
				if (!old_wr) begin
					d.m_rdata = bus.shared_data_lines;
				end
			end
			if (own_old == IMTS_OWN_VIDEO) begin
				d.v_act = 1'b0;
			end else begin
				d.m_act = 1'b0;
				d.m_chan = 1'b0;
			end
		end

		// Latch requests where their high address byte goes out
		if (adv && np == `IMTS_T5) begin
			d.v_act = video_req_i;
			d.v_wr = video_wr_i;
			d.v_addr = video_addr_i;
			d.v_wdata = video_wdata_i;
		end
		if (adv && np == `IMTS_T0) begin
			d.io_sel = main_io_sel_i;
		end
		if (adv && np == `IMTS_T1) begin
			// Channel only served while the main processor allows it
			d.m_chan = q.req_sync[1] & chan_enable_i;
			d.m_act = main_req_i | d.m_chan;
			d.m_wr = d.m_chan ? q.in_sync[1] : main_wr_i;
			d.m_addr = d.m_chan ? q.dma_ptr : main_addr_i;
			d.m_wdata = main_wdata_i;
		end

		unique case (np)
			`IMTS_T5, `IMTS_T6: d.addr = d.v_addr[15:8];
			`IMTS_T7, `IMTS_T0: d.addr = d.v_addr[7:0];
			`IMTS_T1, `IMTS_T2: d.addr = d.m_addr[15:8];
			`IMTS_T3, `IMTS_T4: d.addr = d.m_addr[7:0];
		endcase

		// Data bus and strobes for the owner of the half cycle
		act = (own == IMTS_OWN_MAIN) ? d.m_act : d.v_act;
		wr = (own == IMTS_OWN_MAIN) ? d.m_wr : d.v_wr;
		idx = (own == IMTS_OWN_MAIN) ? d.m_addr[MEM_AW-1:0] : d.v_addr[MEM_AW-1:0];
		d.read_n = ~(act & ~wr);
		// Video write lands at display S7, which is T3
		d.write_n = ~(act & wr & (np == `IMTS_T3 || np == `IMTS_T7));
		// A channel write is the one case the far board drives the bus
		d.doe = act & ~((own == IMTS_OWN_MAIN) & d.m_chan & wr);
		d.dout = wr ? ((own == IMTS_OWN_MAIN) ? d.m_wdata : d.v_wdata) : q.mem[idx];
		d.chan_ack = (own == IMTS_OWN_MAIN) & d.m_chan;
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			q <= '0;
			q.bstrobe_n <= 1'b1;
			q.read_n <= 1'b1;
			q.write_n <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// ==========================================
	// Outputs
	assign bus.master_time_base = q.mclk;
	assign bus.memory_strobe_pulse = q.strobe;
	assign bus.buffered_strobe_n = q.bstrobe_n;
	assign bus.mem_read_n = q.read_n;
	assign bus.mem_write_n = q.write_n;
	assign bus.shared_address_lines = q.addr;
	assign bus.io_select = q.io_sel;
	assign bus.chan_ack = q.chan_ack;
	assign bus.dev_data_out = q.dout;
	assign bus.dev_data_oe = q.doe;
	assign period_o = period;
	assign video_rdata_o = q.v_rdata;
	assign video_done_o = q.v_done;
	assign main_rdata_o = q.m_rdata;
	assign main_done_o = q.m_done;
	assign chan_done_o = q.c_done;
endmodule : imts_slot_master

`default_nettype wire

// file: include/imts_bus_if.sv
`timescale 1ns/100ps
`default_nettype none
`include "imts_defs.svh"

interface imts_bus_if;
	import imts_pkg::*;
	logic master_time_base;
	logic memory_strobe_pulse;
	logic buffered_strobe_n;
	logic mem_read_n;
	logic mem_write_n;
	imts_byte_t shared_address_lines;
	logic [2:0] io_select;
	logic chan_req_n;
	logic chan_in_n;
	logic chan_ack;
	imts_byte_t dev_data_out;
	logic dev_data_oe;
	imts_byte_t oth_data_out;
	logic oth_data_oe;
	imts_byte_t shared_data_lines;

	// ==========================================
	// Released bus floats high
	assign shared_data_lines = dev_data_oe ? dev_data_out :
		(oth_data_oe ? oth_data_out : `IMTS_IDLE_DATA);

	modport dev (
		output master_time_base, memory_strobe_pulse, buffered_strobe_n,
		output mem_read_n, mem_write_n, shared_address_lines, io_select, chan_ack,
		output dev_data_out, dev_data_oe,
		input chan_req_n, chan_in_n, shared_data_lines
	);
	modport oth (
		input master_time_base, memory_strobe_pulse, buffered_strobe_n,
		input mem_read_n, mem_write_n, shared_address_lines, io_select, chan_ack,
		output oth_data_out, oth_data_oe, chan_req_n, chan_in_n,
		input shared_data_lines
	);
endinterface : imts_bus_if

`default_nettype wire

// file: include/imts_defs.svh
`ifndef IMTS_DEFS_SVH
`define IMTS_DEFS_SVH

// ==========================================
// Timing
`define IMTS_CLK_NS 100
`define IMTS_MCLK_PERIOD_NS 326
`define IMTS_MCLK_HALF_RAW ((`IMTS_MCLK_PERIOD_NS / 2) / `IMTS_CLK_NS)
`define IMTS_MCLK_HALF_CYC ((`IMTS_MCLK_HALF_RAW < 1) ? 1 : `IMTS_MCLK_HALF_RAW)
`define IMTS_STRB_DLY_NS 200
`define IMTS_STRB_DLY_RAW (`IMTS_STRB_DLY_NS / `IMTS_CLK_NS)
`define IMTS_STRB_DLY_CYC ((`IMTS_STRB_DLY_RAW < 1) ? 1 : `IMTS_STRB_DLY_RAW)
`define IMTS_MEM_AW 8

// ==========================================
// Period codes
`define IMTS_T0 3'h0
`define IMTS_T1 3'h1
`define IMTS_T2 3'h2
`define IMTS_T3 3'h3
`define IMTS_T4 3'h4
`define IMTS_T5 3'h5
`define IMTS_T6 3'h6
`define IMTS_T7 3'h7
`define IMTS_ALIGN_PERIOD `IMTS_T1
`define IMTS_IDLE_DATA 8'hFF
`define IMTS_ZERO_BYTE 8'h00
`define IMTS_ZERO_ADDR 16'h0000

`endif

// file: include/imts_pkg.sv
`default_nettype none
package imts_pkg;
	typedef logic [2:0] imts_period_t;
	typedef logic [7:0] imts_byte_t;
	typedef logic [15:0] imts_addr_t;
	typedef enum logic {IMTS_OWN_VIDEO, IMTS_OWN_MAIN} imts_owner_t;
endpackage : imts_pkg
`default_nettype wire

// file: verification/imts_bus_chk.sv
`timescale 1ns/100ps
`default_nettype none
module imts_bus_chk (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic master_time_base,
	input wire logic memory_strobe_pulse,
	input wire logic buffered_strobe_n,
	input wire logic mem_write_n,
	input wire logic [2:0] io_select,
	input wire logic chan_ack,
	input wire logic dev_data_oe,
	input wire logic oth_data_oe
);
	logic strb_q;
	logic [3:0] k_q;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	// ==========
	// Cycles since T7 began
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			strb_q <= 1'h0;
			k_q <= 4'h0;
		end else begin
			strb_q <= memory_strobe_pulse;
			k_q <= (memory_strobe_pulse && !strb_q) ? 4'h1 : k_q + 4'h1;
		end
	end
	// ==========
	// Properties
	property p_mclk;
		$rose(master_time_base) |=> $fell(master_time_base) ##1 $rose(master_time_base);
	endproperty
	a_mclk: assert property (p_mclk) else $error("time base not square");
	property p_cyc;
		$rose(memory_strobe_pulse) |-> ##16 $rose(memory_strobe_pulse);
	endproperty
	a_cyc: assert property (p_cyc) else $error("cycle not eight periods");
	property p_strb;
		$rose(memory_strobe_pulse) |-> memory_strobe_pulse[*2] ##1 !memory_strobe_pulse;
	endproperty
	a_strb: assert property (p_strb) else $error("strobe not one period");
	property p_buffered_strobe_n;
		$rose(memory_strobe_pulse) |-> ##2 $fell(buffered_strobe_n) ##2 buffered_strobe_n;
	endproperty
	a_buffered_strobe_n: assert property (p_buffered_strobe_n) else $error("buffered strobe late");
	property p_wr;
		!mem_write_n |-> memory_strobe_pulse || k_q[3:1] == 3'h4;
	endproperty
	a_wr: assert property (p_wr) else $error("write outside T3 or T7");
	property p_ios;
		$changed(io_select) |-> k_q == 4'h2;
	endproperty
	a_ios: assert property (p_ios) else $error("select moved inside cycle");
	property p_ack;
		$rose(chan_ack) |-> chan_ack[*6] ##1 (chan_ack && memory_strobe_pulse)[*2] ##1 !chan_ack;
	endproperty
	a_ack: assert property (p_ack) else $error("ack outside T4 to T7");
	property p_excl;
		!(dev_data_oe && oth_data_oe);
	endproperty
	a_excl: assert property (p_excl) else $error("two data drivers");
	property p_oth;
		oth_data_oe |-> chan_ack && $past(chan_ack, 2);
	endproperty
	a_oth: assert property (p_oth) else $error("far end drives out of slot");
endmodule : imts_bus_chk
`default_nettype wire

// file: verification/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
	typedef struct {logic v; logic w; logic [15:0] a; logic [7:0] d; logic [2:0] io;} imts_row_t;
	logic clk, rst, vreq, vwr, mreq, mwr, cen, xreq, xin;
	logic [15:0] vaddr, maddr;
	logic [7:0] vwd, mwd, xwd, vrd, mrd, xrd;
	logic [2:0] io, mper, xper;
	logic xdone, vdone, mdone, cdone, xbusy, mlive;
	int n_errors = 0;
	int n_tests = 0;
	// Video write lands where main reads; high byte ignored by memory
	imts_row_t rows [5] = '{
		'{1'h0, 1'h1, 16'h1234, 8'hA5, 3'h1},
		'{1'h1, 1'h1, 16'h0001, 8'hC3, 3'h2},
		'{1'h0, 1'h0, 16'hFF34, 8'hA5, 3'h3},
		'{1'h1, 1'h0, 16'h2234, 8'hA5, 3'h4},
		'{1'h0, 1'h0, 16'h0001, 8'hC3, 3'h7}};
	imts_bus_if bus ();
	imts_slot_master i_imts_slot_master (.ref_clk_i(clk), .rst_i(rst), .bus(bus),
		.video_req_i(vreq), .video_wr_i(vwr), .video_addr_i(vaddr), .video_wdata_i(vwd),
		.main_req_i(mreq), .main_wr_i(mwr), .main_addr_i(maddr), .main_wdata_i(mwd),
		.main_io_sel_i(io), .chan_enable_i(cen), .period_o(mper), .video_rdata_o(vrd),
		.video_done_o(vdone), .main_rdata_o(mrd), .main_done_o(mdone), .chan_done_o(cdone));
	imts_chan_node i_imts_chan_node (.ref_clk_i(clk), .rst_i(rst), .bus(bus),
		.xfer_req_i(xreq), .xfer_in_i(xin), .xfer_wdata_i(xwd), .xfer_rdata_o(xrd),
		.xfer_done_o(xdone), .xfer_busy_o(xbusy), .period_o(xper));
	imts_bus_chk i_imts_bus_chk (.ref_clk_i(clk), .rst_i(rst),
		.master_time_base(bus.master_time_base), .memory_strobe_pulse(bus.memory_strobe_pulse),
		.buffered_strobe_n(bus.buffered_strobe_n), .mem_write_n(bus.mem_write_n),
		.io_select(bus.io_select), .chan_ack(bus.chan_ack), .dev_data_oe(bus.dev_data_oe),
		.oth_data_oe(bus.oth_data_oe));
	// ==========
	// Tasks
	task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
		n_tests++;
		if (s !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic give_verdict;
		if (n_errors == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : give_verdict
	// Raised a period and a half before the sampling edge so it is seen there
	task automatic op(input imts_row_t r);
		int n;
		@(posedge clk);
		while (mper !== (r.v ? 3'h3 : 3'h7)) @(posedge clk);
		vreq <= r.v;
		mreq <= !r.v;
		vwr <= r.w;
		mwr <= r.w;
		vaddr <= r.a;
		maddr <= r.a;
		vwd <= r.d;
		mwd <= r.d;
		io <= r.io;
		n = 0;
		while ((r.v ? vdone : mdone) !== 1'h1 && n < 60) begin
			@(posedge clk);
			n++;
		end
		chk("done", r.v ? vdone : mdone, 1'h1);
		chk("done period", mper, r.v ? 3'h4 : 3'h0);
		if (!r.w) chk("rdata", r.v ? vrd : mrd, r.d);
		if (!r.v) chk("io select", bus.io_select, r.io);
		vreq <= 1'h0;
		mreq <= 1'h0;
	endtask : op
	task automatic xf(input logic i, input logic [7:0] d);
		int n;
		int nc;
		@(posedge clk);
		xreq <= 1'h1;
		xin <= i;
		xwd <= d;
		@(posedge clk);
		xreq <= 1'h0;
		n = 0;
		nc = 0;
		while (xdone !== 1'h1 && n < 100) begin
			@(posedge clk);
			n++;
			if (cdone === 1'h1) nc++;
		end
		chk("xfer done", xdone, 1'h1);
		chk("chan done", 16'(nc), 16'h0001);
		chk("xfer busy", xbusy, 1'h0);
		chk("node period", xper, 3'h7);
		if (!i) chk("xfer rdata", xrd, d);
	endtask : xf
	// ==========
	// Address and data schedule
	// Main access is live from its T1 latch until the next T1
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			mlive <= 1'h0;
		end else if (mper == 3'h1) begin
			mlive <= mreq;
		end
	end
	always @(negedge clk) begin
		if (!rst && mreq && mlive && !cen) begin
			if (mper == 3'h2) chk("main hi", bus.shared_address_lines, maddr[15:8]);
			if (mper == 3'h4) chk("main lo", bus.shared_address_lines, maddr[7:0]);
			if (mwr && mper == 3'h7) chk("wdata", bus.shared_data_lines, mwd);
		end
		if (!rst && vreq) begin
			if (mper == 3'h6) chk("video hi", bus.shared_address_lines, vaddr[15:8]);
			if (mper == 3'h0) chk("video lo", bus.shared_address_lines, vaddr[7:0]);
		end
	end
	initial begin
		clk = 1'h0;
		forever #50 clk = ~clk;
	end
	initial begin
		repeat (6000) @(posedge clk);
		n_errors++;
		give_verdict;
	end
	// ==========
	// Main sequence
	initial begin
		{rst, vreq, vwr, mreq, mwr, cen, xreq, xin} = 8'h80;
		{vaddr, maddr, vwd, mwd, xwd, io} = 59'h0;
		repeat (20) @(posedge clk);
		rst <= 1'h0;
		foreach (rows[i]) op(rows[i]);
		cen <= 1'h1;
		xf(1'h1, 8'h77);
		xf(1'h0, 8'hC3);
		cen <= 1'h0;
		op('{1'h0, 1'h0, 16'h0000, 8'h77, 3'h6});
		@(posedge clk);
		rst <= 1'h1;
		repeat (2) @(posedge clk);
		chk("reset period", mper, 3'h0);
		chk("reset write", bus.mem_write_n, 1'h1);
		chk("reset drive", bus.dev_data_oe, 1'h0);
		rst <= 1'h0;
		op('{1'h0, 1'h0, 16'h1234, 8'h00, 3'h5});
		give_verdict;
	end
endmodule : testbench
`default_nettype wire
